/* File: sim/cps_analog_model.sv */
// behavioural model of the two analog comparator cores
`timescale 1ns/1ps
`default_nettype none
module cps_analog_model (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // power and input levels in millivolts
    input  wire logic [1:0]       enable_i,
    input  wire logic [1:0][11:0] pos_mv_i,
    input  wire logic [1:0][11:0] neg_mv_i,
    // raw comparator outputs
    output logic [1:0]            result_o
);
    logic [1:0] junk_q;

    // an unpowered core has no valid answer, so it shows a changing pattern
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            junk_q <= 2'h0;
        else
            junk_q <= ~junk_q;
    end

    // a powered core answers at once, one only when positive is above negative
    always_comb begin
        for (int k = 0; k < 2; k++)
            result_o[k] = enable_i[k] ? (pos_mv_i[k] > neg_mv_i[k]) : junk_q[k];
    end
endmodule : cps_analog_model
`default_nettype wire

/* File: sim/cps_comparator_pair_sequencer_tb.sv */
// self-checking bench for the comparator pair sequencer
`timescale 1ns/1ps
`default_nettype none
module cps_comparator_pair_sequencer_tb;
    localparam int W = cps_pkg::STARTUP_CYC;
    logic clock_i, rst_n_i, main_wr, sw_rst, ev_wr, win_wr, rd_start, sleep, wake;
    logic stall, wev, dbl, creq, r;
    logic [1:0]  cc_wr, start, ev_in, ana, cur, done, wst, aen, cev, ws, pw, prev;
    logic [2:0]  int_en, fclr, flag;
    logic [31:0] lfsr;
    logic [1:0][11:0] pos, neg;
    cps_pkg::cps_main_control_type               main_d;
    cps_pkg::cps_event_control_type              ev_d;
    cps_pkg::cps_comparator_control_type         cc_d;
    cps_pkg::cps_window_control_type             win_d;
    cps_pkg::cps_comparator_control_type [1:0]   cc_q;
    int fail_count, check_count, cyc, n;

    cps_comparator_pair_sequencer cps_comparator_pair_sequencer_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .main_wr_i(main_wr), .main_data_i(main_d),
        .software_reset_i(sw_rst), .event_control_wr_i(ev_wr), .event_control_data_i(ev_d),
        .comparator_control_wr_i(cc_wr), .comparator_control_data_i(cc_d),
        .window_control_wr_i(win_wr), .window_control_data_i(win_d),
        .start_comparison_i(start), .read_to_start_i(rd_start), .event_in_i(ev_in),
        .int_enable_i(int_en), .flag_clear_i(fclr), .sleep_i(sleep), .wake_enable_i(wake),
        .analog_result_i(ana), .current_result_o(cur), .comparison_done_o(done),
        .window_state_o(wst), .interrupt_flag_o(flag), .read_stall_o(stall),
        .comparator_event_o(cev), .window_event_o(wev), .analog_enable_o(aen),
        .doubler_on_o(dbl), .sampling_clock_request_o(creq), .comparator_control_o(cc_q));

    cps_analog_model cps_analog_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .enable_i(aen), .pos_mv_i(pos), .neg_mv_i(neg), .result_o(ana));

    ////////////////////////////////////////////////////////////////////////////////
    // expectations and random source
    function automatic logic [11:0] rnd();
        repeat (12) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[11:0];
    endfunction : rnd
    function automatic logic exp_int(input logic [1:0] s, input logic p, input logic c);
        case (s)
            cps_pkg::ISEL_TOGGLE: return p != c;
            cps_pkg::ISEL_RISE:   return !p && c;
            cps_pkg::ISEL_FALL:   return p && !c;
            default:              return 1'b1;
        endcase
    endfunction : exp_int
    // comparator 0 holds the upper limit, so a split answer means inside
    function automatic logic [1:0] exp_ws(input logic [1:0] q);
        if (q[0] != q[1])
            return cps_pkg::WST_INSIDE;
        return q[0] ? cps_pkg::WST_ABOVE : cps_pkg::WST_BELOW;
    endfunction : exp_ws
    function automatic logic exp_wi(input logic [1:0] s, input logic [1:0] p, input logic [1:0] c);
        case (s)
            cps_pkg::WSEL_ABOVE:  return c == cps_pkg::WST_ABOVE && p != cps_pkg::WST_ABOVE;
            cps_pkg::WSEL_INSIDE: return c == cps_pkg::WST_INSIDE && p != cps_pkg::WST_INSIDE;
            cps_pkg::WSEL_BELOW:  return c == cps_pkg::WST_BELOW && p != cps_pkg::WST_BELOW;
            default:              return c != cps_pkg::WST_INSIDE && p == cps_pkg::WST_INSIDE;
        endcase
    endfunction : exp_wi

    ////////////////////////////////////////////////////////////////////////////////
    // drivers, all changes land at the falling edge
    task tick(input int k);
        repeat (k) @(negedge clock_i);
    endtask : tick
    task chk(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task pulse_cc(input int i, input logic en, input logic sg, input logic [1:0] is);
        cc_d = {en, sg, is, 3'h0, 3'h1};
        cc_wr[i] = 1'b1;
        tick(1);
        cc_wr = 2'h0;
        tick(1); // quiet edge: strobe never re-raised in one step, phase settles
    endtask : pulse_cc
    task set_main(input logic en, input logic doff);
        main_d = {en, doff};
        main_wr = 1'b1;
        tick(1);
        main_wr = 1'b0;
    endtask : set_main
    // bounded wait for ready bits; a loose upper bound absorbs the synchroniser
    task wait_ready(input logic [1:0] w, input int lo);
        while ((done & w) !== w && n < 2000) begin
            tick(1);
            n++;
        end
        chk(n >= lo && n <= lo + 5, 1'b1);
    endtask : wait_ready
    // kind 0 start bit, 1 input event, 2 status read
    task shot(input int kind, input logic [1:0] m, input logic [1:0] w);
        case (kind)
            0: start = m;
            1: ev_in = m;
            default: rd_start = 1'b1;
        endcase
        tick(1);
        start = 2'h0;
        ev_in = 2'h0;
        rd_start = 1'b0;
        tick(1);
        chk(done & w, 2'h0);
        if (kind == 2) chk(stall, 1'b1);
        n = 2;
        wait_ready(w, W);
    endtask : shot
    task conclude();
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // main sequence
    initial begin
        {rst_n_i, main_wr, sw_rst, ev_wr, win_wr, rd_start, sleep, wake} = '0;
        {cc_wr, start, ev_in, fclr, main_d, ev_d, cc_d, win_d, pos, neg} = '0;
        int_en = 3'h7;
        lfsr = 32'h0001_5418;
        tick(5);
        rst_n_i = 1'b1;
        tick(1);
        chk({flag, done, aen, cur}, 12'h000);
        ev_d = 5'h1f;
        ev_wr = 1'b1;
        tick(1);
        ev_wr = 1'b0;
        set_main(1'b1, 1'b1);
        // every interrupt condition over random single shots
        for (int is = 0; is < 4; is++) begin
            pulse_cc(0, 1'b0, 1'b1, is[1:0]);
            pulse_cc(0, 1'b1, 1'b1, is[1:0]);
            for (int k = 0; k < 4; k++) begin
                pos[0] = rnd();
                neg[0] = rnd();
                r = pos[0] > neg[0];
                fclr = 3'h1;
                tick(1);
                fclr = 3'h0;
                shot(0, 2'h1, 2'h1);
                chk(cur[0], r);
                chk(cev[0], r);
                chk(aen[0], 1'b0);
                if (k > 0) chk(flag[0], exp_int(is[1:0], prev[0], r));
                prev[0] = r;
            end
        end
        // locked settings, events without interrupt enable
        int_en = 3'h0;
        ev_d = 5'h00;
        ev_wr = 1'b1;
        pulse_cc(0, 1'b1, 1'b0, 2'h0);
        ev_wr = 1'b0;
        chk(flag[0], 1'b0);
        chk({cc_q[0].single, cc_q[0].interrupt_condition_select}, 3'h7);
        pos[0] = 12'h0c00;
        neg[0] = 12'h0100;
        shot(1, 2'h1, 2'h1);
        chk(cev[0], 1'b1);
        // continuous mode with the doubler running
        int_en = 3'h7;
        pulse_cc(0, 1'b0, 1'b0, cps_pkg::ISEL_TOGGLE);
        set_main(1'b1, 1'b0);
        pulse_cc(0, 1'b1, 1'b0, cps_pkg::ISEL_TOGGLE);
        n = 1;
        wait_ready(2'h1, W + cps_pkg::DOUBLER_CYC);
        chk({dbl, cur[0]}, 2'h3);
        pos[0] = 12'h0010;
        tick(5);
        chk({cur[0], flag[0]}, 2'h1);
        set_main(1'b0, 1'b1);
        tick(2);
        chk({aen[0], cc_q[0].enable}, 2'h1);
        set_main(1'b1, 1'b1);
        tick(10);
        chk({aen[0], dbl}, 2'h2);
        // software reset leaves everything cleared and the block off
        sw_rst = 1'b1;
        tick(1);
        sw_rst = 1'b0;
        pulse_cc(1, 1'b1, 1'b0, 2'h0);
        tick(20);
        chk({flag, done, aen, cur, cc_q[0].enable}, 12'h000);
        // status read and events on a single-shot pair
        ev_d = 5'h1f;
        ev_wr = 1'b1;
        tick(1);
        ev_wr = 1'b0;
        set_main(1'b1, 1'b1);
        pulse_cc(1, 1'b0, 1'b1, cps_pkg::ISEL_END);
        pulse_cc(0, 1'b1, 1'b1, cps_pkg::ISEL_END);
        pulse_cc(1, 1'b1, 1'b1, cps_pkg::ISEL_END);
        neg = {12'h05dc, 12'h09c4};
        pos = {12'h0700, 12'h0700};
        shot(2, 2'h0, 2'h3);
        tick(2);
        chk({stall, cur}, 3'h2);
        shot(1, 2'h2, 2'h2);
        chk(done[0], 1'b1);
        // window mode under every window interrupt selection
        for (int s = 0; s < 4; s++) begin
            win_d = {1'b1, s[1:0]};
            win_wr = 1'b1;
            tick(1);
            win_wr = 1'b0;
            for (int k = 0; k < 5; k++) begin
                pos[0] = rnd();
                pos[1] = pos[0];
                ws = exp_ws({pos[1] > neg[1], pos[0] > neg[0]});
                fclr = 3'h4;
                tick(1);
                fclr = 3'h0;
                shot(k % 2, k % 2 ? 2'h2 : 2'h1, 2'h3);
                chk(wst, ws);
                chk(wev, ws == cps_pkg::WST_INSIDE);
                if (k > 0) chk(flag[2], exp_wi(s[1:0], pw, ws));
                pw = ws;
            end
        end
        // event shot while asleep asks for the sampling clock, then lets go
        win_d = 3'h0;
        win_wr = 1'b1;
        sleep = 1'b1;
        ev_in = 2'h1;
        tick(1);
        {win_wr, ev_in} = '0;
        tick(10);
        chk(creq, 1'b1);
        n = 11;
        wait_ready(2'h1, W);
        tick(3);
        chk({creq, aen[0]}, 2'h0);
        conclude();
    end
endmodule : cps_comparator_pair_sequencer_tb
`default_nettype wire

/* File: verilog/cps_comparator_pair_sequencer.sv */
// digital sequencer for a pair of analog comparators
`timescale 1ns/1ps
`default_nettype none
module cps_comparator_pair_sequencer (
    // clock and reset
    input  wire logic                                   clock_i,
    input  wire logic                                   rst_n_i,
    // configuration writes
    input  wire logic                                   main_wr_i,
    input  wire cps_pkg::cps_main_control_type          main_data_i,
    input  wire logic                                   software_reset_i,
    input  wire logic                                   event_control_wr_i,
    input  wire cps_pkg::cps_event_control_type         event_control_data_i,
    input  wire logic [1:0]                             comparator_control_wr_i,
    input  wire cps_pkg::cps_comparator_control_type    comparator_control_data_i,
    input  wire logic                                   window_control_wr_i,
    input  wire cps_pkg::cps_window_control_type        window_control_data_i,
    // commands and events
    input  wire logic [1:0]                             start_comparison_i,
    input  wire logic                                   read_to_start_i,
    input  wire logic [1:0]                             event_in_i,
    input  wire logic [2:0]                             int_enable_i,
    input  wire logic [2:0]                             flag_clear_i,
    input  wire logic                                   sleep_i,
    input  wire logic                                   wake_enable_i,
    // raw analog comparator outputs, asynchronous
    input  wire logic [1:0]                             analog_result_i,
    // status
    output logic [1:0]                                  current_result_o,
    output logic [1:0]                                  comparison_done_o,
    output logic [1:0]                                  window_state_o,
    output logic [2:0]                                  interrupt_flag_o,
    output logic                                        read_stall_o,
    // events and analog controls
    output logic [1:0]                                  comparator_event_o,
    output logic                                        window_event_o,
    output logic [1:0]                                  analog_enable_o,
    output logic                                        doubler_on_o,
    output logic                                        sampling_clock_request_o,
    output cps_pkg::cps_comparator_control_type [1:0]   comparator_control_o
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        cps_pkg::cps_main_control_type               main;
        cps_pkg::cps_event_control_type              evc;
        cps_pkg::cps_window_control_type             winc;
        cps_pkg::cps_comparator_control_type [1:0]   comp;
        cps_pkg::cps_phase_type [1:0]                phase;
        logic [1:0][cps_pkg::CNT_W-1:0]              cnt;
        logic [1:0]                                  sync1;
        logic [1:0]                                  sync2;
        logic [1:0]                                  result;
        logic [1:0]                                  ready;
        logic [2:0]                                  flag;
        logic [1:0]                                  wstate;
        logic                                        stall;
        logic                                        clk_req;
        logic [1:0]                                  cev;
        logic                                        wev;
        logic [1:0]                                  aen;
        logic                                        dbl;
    } cps_state_type;

    cps_state_type s_q;
    cps_state_type s_d;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [1:0] act;
        logic [1:0] trig;
        logic [1:0] done;
        logic [1:0] busy;
        logic [2:0] set;
        logic       tog;
        logic       rise;
        logic       fall;
        logic [1:0] ws;
        logic [cps_pkg::CNT_W-1:0] warm;
        act  = '0;
        trig = '0;
        done = '0;
        busy = '0;
        set  = '0;
        tog  = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        ws   = '0;
        warm = cps_pkg::cps_warm_cycles(s_q.main.doubler_off_bit);
        s_d  = s_q;
        // synchroniser on the raw analog outputs
        s_d.sync1 = analog_result_i;
        s_d.sync2 = s_q.sync1;
        if (software_reset_i) begin
            s_d = '0;
        end else begin
            if (main_wr_i)
                s_d.main = main_data_i;
            // event routing fixed while the block runs
            if (event_control_wr_i && !s_q.main.enable)
                s_d.evc = event_control_data_i;
            if (window_control_wr_i)
                s_d.winc = window_control_data_i;
            // start sources per comparator
            for (int i = 0; i < 2; i++) begin
                act[i]  = s_q.main.enable && s_q.comp[i].enable;
                trig[i] = start_comparison_i[i]
                        || (event_in_i[i] && s_q.evc.event_trigger_enable[i])
                        || (read_to_start_i && s_q.comp[i].single);
            end
            // window pair in single shot launches both together
            if (s_q.winc.window_enable_bit && s_q.comp[0].single && s_q.comp[1].single)
                trig = {2{|trig}};
            for (int i = 0; i < 2; i++) begin
                // settings locked while enabled; only the enable itself may drop
                if (comparator_control_wr_i[i]) begin
                    if (!s_q.comp[i].enable)
                        s_d.comp[i] = comparator_control_data_i;
                    else
                        s_d.comp[i].enable = comparator_control_data_i.enable;
                end
                case (s_q.phase[i])
                    cps_pkg::PH_OFF: begin
                        if (act[i] && s_q.comp[i].single) begin
                            s_d.phase[i] = cps_pkg::PH_IDLE;
                        end else if (act[i]) begin
                            s_d.phase[i] = cps_pkg::PH_WARM;
                            s_d.cnt[i]   = warm;
                            s_d.ready[i] = 1'b0;
                        end
                    end
                    cps_pkg::PH_WARM: begin
                        if (!act[i]) begin
                            s_d.phase[i] = cps_pkg::PH_OFF;
                        end else if (s_q.cnt[i] <= 1) begin
                            done[i]      = 1'b1;
                            s_d.phase[i] = s_q.comp[i].single ? cps_pkg::PH_IDLE
                                                              : cps_pkg::PH_RUN;
                        end else begin
                            s_d.cnt[i] = s_q.cnt[i] - 1'b1;
                        end
                    end
                    cps_pkg::PH_RUN: begin
                        if (!act[i])
                            s_d.phase[i] = cps_pkg::PH_OFF;
                        else
                            done[i] = 1'b1;
                    end
                    cps_pkg::PH_IDLE: begin
                        if (!act[i]) begin
                            s_d.phase[i] = cps_pkg::PH_OFF;
                        end else if (trig[i]) begin
                            s_d.phase[i] = cps_pkg::PH_WARM;
                            s_d.cnt[i]   = warm;
                            s_d.ready[i] = 1'b0;
                        end
                    end
                    default: s_d.phase[i] = cps_pkg::PH_OFF;
                endcase
                // a completed comparison: result, ready, edge against last result
                if (done[i]) begin
                    s_d.result[i] = s_q.sync2[i];
                    s_d.ready[i]  = 1'b1;
                    rise = s_q.sync2[i] && !s_q.result[i];
                    fall = !s_q.sync2[i] && s_q.result[i];
                    case (s_q.comp[i].interrupt_condition_select)
                        cps_pkg::ISEL_TOGGLE: set[i] = rise || fall;
                        cps_pkg::ISEL_RISE:   set[i] = rise;
                        cps_pkg::ISEL_FALL:   set[i] = fall;
                        default:              set[i] = 1'b1;
                    endcase
                    tog = tog || rise || fall;
                end
                busy[i] = s_d.phase[i] == cps_pkg::PH_WARM;
                s_d.aen[i] = busy[i] || s_d.phase[i] == cps_pkg::PH_RUN;
                s_d.cev[i] = s_d.evc.out_en[i] && s_d.result[i];
            end
            // window state: differing results mean inside
            if (s_d.result[0] != s_d.result[1])
                ws = cps_pkg::WST_INSIDE;
            else if (s_d.result[0])
                ws = cps_pkg::WST_ABOVE;
            else
                ws = cps_pkg::WST_BELOW;
            s_d.wstate = ws;
            if (s_q.winc.window_enable_bit && ws != s_q.wstate) begin
                case (s_q.winc.window_interrupt_select)
                    cps_pkg::WSEL_ABOVE:  set[2] = ws == cps_pkg::WST_ABOVE;
                    cps_pkg::WSEL_INSIDE: set[2] = ws == cps_pkg::WST_INSIDE;
                    cps_pkg::WSEL_BELOW:  set[2] = ws == cps_pkg::WST_BELOW;
                    // leaving only: a jump from above straight to below is no exit
                    default:              set[2] = ws != cps_pkg::WST_INSIDE
                                                 && s_q.wstate == cps_pkg::WST_INSIDE;
                endcase
            end
            s_d.wev = s_d.winc.window_enable_bit && s_d.evc.win_out_en
                    && ws == cps_pkg::WST_INSIDE;
            // clear by write-one or disable, but a new event wins
            s_d.flag = (s_q.flag & ~flag_clear_i & int_enable_i) | set;
            // stall held while either comparator, single shot or continuous, is still warming
            s_d.stall = (read_to_start_i || s_q.stall) && |busy;
            s_d.dbl   = !s_d.main.doubler_off_bit && |s_d.aen;
            // clock asked for while warming or on a toggle, kept only for wake
            s_d.clk_req = sleep_i && (|busy || tog
                        || (s_q.clk_req && wake_enable_i));
        end
    end

    // single register stage for the whole state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign current_result_o         = s_q.result;
    assign comparison_done_o        = s_q.ready;
    assign window_state_o           = s_q.wstate;
    assign interrupt_flag_o         = s_q.flag;
    assign read_stall_o             = s_q.stall;
    assign comparator_event_o       = s_q.cev;
    assign window_event_o           = s_q.wev;
    assign analog_enable_o          = s_q.aen;
    assign doubler_on_o             = s_q.dbl;
    assign sampling_clock_request_o = s_q.clk_req;
    assign comparator_control_o     = s_q.comp;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_event_lock: assert property (
        s_q.main.enable && !software_reset_i |=> $stable(s_q.evc))
        else $error("event control changed while enabled");

    chk_mux_lock: assert property (
        s_q.comp[0].enable && !software_reset_i |=>
            s_q.comp[0].positive_input_select == $past(s_q.comp[0].positive_input_select))
        else $error("input select changed while comparator enabled");

    chk_global_stop: assert property (
        !s_q.main.enable ##1 !s_q.main.enable |-> s_q.phase[1] == cps_pkg::PH_OFF)
        else $error("comparator running with block disabled");

    chk_soft_reset: assert property (
        software_reset_i |=> !s_q.main.enable && s_q.flag == 3'h0 && !s_q.ready[0])
        else $error("software reset left state behind");

    chk_startup_hold: assert property (
        s_q.phase[0] == cps_pkg::PH_WARM && s_q.cnt[0] > 1 && !software_reset_i
        |=> $stable(s_q.result[0]))
        else $error("result updated during start-up");

    chk_start_clear: assert property (
        s_q.phase[0] == cps_pkg::PH_IDLE && s_q.main.enable && s_q.comp[0].enable
        && start_comparison_i[0] && !software_reset_i
        |=> !s_q.ready[0] && s_q.phase[0] == cps_pkg::PH_WARM)
        else $error("start did not clear ready");

    chk_pair_launch: assert property (
        s_q.winc.window_enable_bit && s_q.comp[0].single && s_q.comp[1].single
        && s_q.phase == {cps_pkg::PH_IDLE, cps_pkg::PH_IDLE} && s_q.main.enable
        && s_q.comp[0].enable && s_q.comp[1].enable && start_comparison_i[0]
        && !software_reset_i |=> s_q.phase[1] == cps_pkg::PH_WARM)
        else $error("window pair not started together");

    chk_flag_sticky: assert property (
        s_q.flag[2] && int_enable_i[2] && !flag_clear_i[2] && !software_reset_i
        |=> s_q.flag[2])
        else $error("interrupt flag lost");

    chk_event_follow: assert property (
        s_q.cev[1] == (s_q.evc.out_en[1] && s_q.result[1]))
        else $error("comparator event not following result");

    chk_read_stall: assert property (
        read_to_start_i && s_q.phase[1] == cps_pkg::PH_IDLE && s_q.comp[1].single
        && s_q.main.enable && s_q.comp[1].enable && !software_reset_i |=> s_q.stall)
        else $error("status read did not stall");

endmodule : cps_comparator_pair_sequencer
`default_nettype wire

/* File: verilog/cps_pkg.sv */
// constants and carrier types for the comparator pair sequencer
// Functional notes
// - result is one when positive exceeds negative
// - event and comparator settings locked while enabled
// - global disable stops comparators, keeps their enables
// - software reset clears all state, block disabled
// - no result updates until start-up delay elapses
// - doubler off bit drops doubler settling time
// - interrupt select: toggle, rise, fall, end
// - output events follow result regardless of interrupts
// - continuous mode compares every cycle after start-up
// - continuous edges from present versus previous sample
// - sleep toggle requests sampling clock, then releases
// - single shot idles, one comparison per start
// - start bit clears ready, done sets it
// - status read starts idle single shots, stalls
// - enabled input event starts that single shot
// - single-shot edges from newest versus previous result
// - sleep event shot requests clock, powers comparator
// - window interrupt select: above, inside, below, outside
// - window event follows inside state, state readable
// - window single shot starts both comparators together
// - flags sticky until write-one, disable, or reset
package cps_pkg;

    // timing, at a 5 ns clock
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned STARTUP_NS  = 1000;
    localparam int unsigned DOUBLER_NS  = 500;
    localparam int unsigned STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DOUBLER_CYC = (DOUBLER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W       = 12;

    // comparator interrupt condition codes
    localparam logic [1:0] ISEL_TOGGLE = 2'h0;
    localparam logic [1:0] ISEL_RISE   = 2'h1;
    localparam logic [1:0] ISEL_FALL   = 2'h2;
    localparam logic [1:0] ISEL_END    = 2'h3;

    // window interrupt codes and window state codes
    localparam logic [1:0] WSEL_ABOVE   = 2'h0;
    localparam logic [1:0] WSEL_INSIDE  = 2'h1;
    localparam logic [1:0] WSEL_BELOW   = 2'h2;
    localparam logic [1:0] WSEL_OUTSIDE = 2'h3;
    localparam logic [1:0] WST_ABOVE    = 2'h0;
    localparam logic [1:0] WST_INSIDE   = 2'h1;
    localparam logic [1:0] WST_BELOW    = 2'h2;

    typedef enum logic [1:0] {
        PH_OFF  = 2'b00,
        PH_WARM = 2'b01,
        PH_RUN  = 2'b10,
        PH_IDLE = 2'b11
    } cps_phase_type;

    typedef struct packed {
        logic       enable;
        logic       single;
        logic [1:0] interrupt_condition_select;
        logic [2:0] positive_input_select;
        logic [2:0] negative_input_select;
    } cps_comparator_control_type;

    typedef struct packed {
        logic [1:0] out_en;
        logic       win_out_en;
        logic [1:0] event_trigger_enable;
    } cps_event_control_type;

    typedef struct packed {
        logic       window_enable_bit;
        logic [1:0] window_interrupt_select;
    } cps_window_control_type;

    typedef struct packed {
        logic enable;
        logic doubler_off_bit;
    } cps_main_control_type;

    // start-up length in cycles, doubler settling skipped when it is off
    function automatic logic [CNT_W-1:0] cps_warm_cycles(input logic doubler_off);
        if (doubler_off)
            return CNT_W'(STARTUP_CYC);
        return CNT_W'(STARTUP_CYC + DOUBLER_CYC);
    endfunction : cps_warm_cycles

endpackage : cps_pkg
